// [dsc_cfg.svh]
// Offsets, field positions, reset values and counts of the deep sleep controller.
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// Register byte offsets on the AXI4-Lite slave.
`define DSC_OFF_CTRL   8'h00
`define DSC_OFF_WAKE   8'h04
`define DSC_OFF_RET0   8'h08
`define DSC_OFF_RET1   8'h0C
`define DSC_OFF_STAT   8'h10

// Fields of the deep sleep control register.
`define DSC_CTRL_ARM   15
`define DSC_CTRL_CALOFF 8
`define DSC_CTRL_SLOWOFF 2
`define DSC_CTRL_BOR   1
`define DSC_CTRL_HOLD  0
`define DSC_CTRL_WMASK 16'h8106

// Fields of the wake cause register.
`define DSC_WAKE_INT   8
`define DSC_WAKE_FLT   7
`define DSC_WAKE_WDT   4
`define DSC_WAKE_CAL   3
`define DSC_WAKE_EXTERNAL_RESET_PIN  2
`define DSC_WAKE_POR   0
`define DSC_WAKE_WMASK 16'h019D

// Fields of the reset status register.
`define DSC_STAT_EXIT  0
`define DSC_STAT_POR   1

// Register reset values.
`define DSC_CTRL_RST   16'h0000
`define DSC_WAKE_RST   16'h0000

// Watchdog: last count is 2^(BASE + STEP * postscale) - 1 slow ticks.
`define DSC_WDT_BASE   6
`define DSC_WDT_STEP   2
`define DSC_WDT_W      36

// Bus answers.
`define DSC_RESP_OK    2'b00
`define DSC_RESP_ERR   2'b10

`endif

// [dsc_pkg.sv]
// Types shared by the deep sleep controller and its surroundings.
package dsc_pkg;

  // Operating mode, one-hot.
  typedef enum logic [2:0] {
    DSC_RUN  = 3'b001,
    DSC_DEEP = 3'b010,
    DSC_EXIT = 3'b100
  } dsc_mode_type;

  // Fuse-level configuration word fields.
  typedef struct packed {
    logic       deep_watchdog_on;
    logic       deep_brownout_on;
    logic       deep_watchdog_clk_sel;
    logic       calendar_clk_sel;
    logic [3:0] deep_watchdog_prescale;
  } dsc_cfg_type;

  // Raw wake and supply events, one-cycle pulses.
  typedef struct packed {
    logic ext_interrupt_zero;
    logic fault;
    logic calendar_alarm;
    logic external_reset_pin;
    logic power_on;
    logic deep_brownout;
  } dsc_evt_type;

  // Slow oscillator ticks, one-cycle pulses.
  typedef struct packed {
    logic secondary_oscillator;
    logic low_power_rc_osc;
  } dsc_tick_type;

endpackage : dsc_pkg

// [dsc_top.sv]
// Deep sleep controller: pin hold, wake causes, deep watchdog, AXI4-Lite registers.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "dsc_cfg.svh"

module dsc_top
  import dsc_pkg::*;
#(
  parameter int NPINS = 16,
  parameter int WDT_W = `DSC_WDT_W
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire dsc_cfg_type        cfg,
  input  wire dsc_evt_type        evt,
  input  wire dsc_tick_type       tick,
  input  wire logic               sleep_cmd,
  input  wire logic [NPINS-1:0]   pin_direction_bits,
  input  wire logic [NPINS-1:0]   pin_latch_bits,
  input  wire logic               secondary_osc_on,
  output logic [NPINS-1:0]        pin_out,
  output logic [NPINS-1:0]        pin_oe_n,
  output logic                    secondary_oscillator_run,
  output logic                    low_power_rc_run,
  output logic                    calendar_tick,
  output logic                    deep_sleep_active,
  output logic                    wake_reset,
  output logic                    port_regs_clear,
  output logic                    osc_on_clear,
  output logic                    por_rearm,
  output logic                    deep_exit_status,
  output logic                    power_on_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks.

  // The watchdog must hold the longest postscale count.
  if (WDT_W < `DSC_WDT_BASE + `DSC_WDT_STEP * 15) begin : g_bad_wdt
    $error("WDT_W too small for the longest postscale setting.");
  end
  if (NPINS < 1 || NPINS > 32) begin : g_bad_pins
    $error("NPINS must lie between 1 and 32.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    dsc_mode_type     mode;
    logic [15:0]      ctrl;
    logic [15:0]      wake;
    logic [15:0]      ret0;
    logic [15:0]      ret1;
    logic             st_exit;
    logic             st_por;
    logic [NPINS-1:0] frz_dir;
    logic [NPINS-1:0] frz_lat;
    logic             frz_osc;
    logic             pin_rst;
    logic [WDT_W-1:0] wdt_cnt;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       aw_a;
    logic [31:0]      w_d;
    logic [3:0]       w_s;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe_n;
    logic             cal_tick;
    logic             wreset;
    logic             port_clr;
    logic             osc_clr;
    logic             rearm;
  } dsc_state_type;

  dsc_state_type q;
  dsc_state_type d;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Register index of an address; 3'h7 marks an unmapped address.
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    reg_sel = 3'h7;
    // Byte lanes are ignored; each register takes one aligned word.
    case ({a[7:2], 2'b00})
      `DSC_OFF_CTRL: reg_sel = 3'h0;
      `DSC_OFF_WAKE: reg_sel = 3'h1;
      `DSC_OFF_RET0: reg_sel = 3'h2;
      `DSC_OFF_RET1: reg_sel = 3'h3;
      `DSC_OFF_STAT: reg_sel = 3'h4;
      default:       reg_sel = 3'h7;
    endcase
  endfunction : reg_sel

  // Byte-lane write of a 16-bit register limited to its writable bits.
  function automatic logic [15:0] wr16(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0]  stb,
    input logic [15:0] msk
  );
    logic [15:0] nv;
    nv = {stb[1] ? dat[15:8] : old[15:8], stb[0] ? dat[7:0] : old[7:0]};
    wr16 = (old & ~msk) | (nv & msk);
  endfunction : wr16

  // Last watchdog count for a postscale setting.
  function automatic logic [WDT_W-1:0] wdt_last(input logic [3:0] ps);
    wdt_last = (WDT_W'(1) << (`DSC_WDT_BASE + `DSC_WDT_STEP * ps)) - WDT_W'(1);
  endfunction : wdt_last

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection and wake decode.

  logic wdt_tick;
  logic wdt_to;
  logic in_deep;
  logic w_cal;
  logic wake_any;
  logic bor_hit;

  // Each slow consumer takes its tick from the oscillator its fuse picks.
  assign wdt_tick = cfg.deep_watchdog_clk_sel ? tick.low_power_rc_osc
                                               : tick.secondary_oscillator;
  assign in_deep  = (q.mode == DSC_DEEP);
  // The ordinary watchdog plays no part here.
  assign wdt_to   = in_deep && cfg.deep_watchdog_on && wdt_tick
                    && (q.wdt_cnt == wdt_last(cfg.deep_watchdog_prescale));
  assign w_cal    = evt.calendar_alarm && !q.ctrl[`DSC_CTRL_CALOFF];
  assign wake_any = evt.ext_interrupt_zero || evt.fault || w_cal || wdt_to
                    || evt.external_reset_pin || evt.power_on;
  assign bor_hit  = in_deep && cfg.deep_brownout_on && evt.deep_brownout;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Software writes are applied first and hardware sets after them,
  // so an event in the cycle of a clear is never lost.
  always_comb begin
    logic       do_wr;
    logic [2:0] ws;
    logic [2:0] rs;
    do_wr      = 1'b0;
    ws         = 3'h7;
    rs         = 3'h7;
    d          = q;
    d.wreset   = 1'b0;
    d.port_clr = 1'b0;
    d.osc_clr  = 1'b0;
    d.rearm    = 1'b0;
    d.cal_tick = cfg.calendar_clk_sel ? tick.low_power_rc_osc
                                      : tick.secondary_oscillator;

    // Write address and data are taken in either order.
    if (awvalid && awready) begin
      d.aw_got = 1'b1;
      d.aw_a   = awaddr;
    end
    if (wvalid && wready) begin
      d.w_got = 1'b1;
      d.w_d   = wdata;
      d.w_s   = wstrb;
    end
    do_wr = q.aw_got && q.w_got && !q.bvalid;
    ws    = reg_sel(q.aw_a);
    if (do_wr) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = (ws == 3'h7) ? `DSC_RESP_ERR : `DSC_RESP_OK;
      case (ws)
        3'h0: begin
          d.ctrl = wr16(q.ctrl, q.w_d, q.w_s, `DSC_CTRL_WMASK);
          // Software can only clear the hold bit, never set it.
          if (q.w_s[0] && !q.w_d[`DSC_CTRL_HOLD]) begin
            d.ctrl[`DSC_CTRL_HOLD] = 1'b0;
          end
          if (q.w_s[1] && q.w_d[`DSC_CTRL_ARM]) begin
            d.wake = `DSC_WAKE_RST;
          end
        end
        3'h1: d.wake = wr16(q.wake, q.w_d, q.w_s, `DSC_WAKE_WMASK);
        3'h2: d.ret0 = wr16(q.ret0, q.w_d, q.w_s, 16'hFFFF);
        3'h3: d.ret1 = wr16(q.ret1, q.w_d, q.w_s, 16'hFFFF);
        3'h4: begin
          if (q.w_s[0] && !q.w_d[`DSC_STAT_EXIT]) begin
            d.st_exit = 1'b0;
          end
          if (q.w_s[0] && !q.w_d[`DSC_STAT_POR]) begin
            d.st_por = 1'b0;
          end
        end
        default: d.bresp = `DSC_RESP_ERR;
      endcase
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    rs = reg_sel(araddr);
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rresp  = `DSC_RESP_OK;
      case (rs)
        3'h0:    d.rdata = {16'h0000, q.ctrl};
        3'h1:    d.rdata = {16'h0000, q.wake};
        3'h2:    d.rdata = {16'h0000, q.ret0};
        3'h3:    d.rdata = {16'h0000, q.ret1};
        3'h4:    d.rdata = {30'h0, q.st_por, q.st_exit};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = `DSC_RESP_ERR;
        end
      endcase
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end

    // A power-on event is recorded whatever the mode.
    if (evt.power_on) begin
      d.st_por                = 1'b1;
      d.wake[`DSC_WAKE_POR]   = 1'b1;
    end

    case (q.mode)
      DSC_RUN: begin
        // Entry needs the arm bit; the key sequence is software's job.
        if (sleep_cmd && q.ctrl[`DSC_CTRL_ARM]) begin
          d.mode    = DSC_DEEP;
          d.ctrl[`DSC_CTRL_HOLD] = 1'b1;
          d.frz_dir = pin_direction_bits;
          d.frz_lat = pin_latch_bits;
          d.frz_osc = secondary_osc_on;
          d.pin_rst = 1'b0;
          d.wdt_cnt = '0;
          d.st_exit = 1'b1;
        end
      end
      DSC_DEEP: begin
        // Counting starts at the first tick of a possibly cold oscillator.
        if (cfg.deep_watchdog_on && wdt_tick) begin
          d.wdt_cnt = q.wdt_cnt + WDT_W'(1);
        end
        // Brown-out never wakes; it drops retained state and re-arms.
        if (bor_hit) begin
          d.ctrl[`DSC_CTRL_BOR]  = 1'b1;
          d.ctrl[`DSC_CTRL_HOLD] = 1'b0;
          d.ret0  = 16'h0000;
          d.ret1  = 16'h0000;
          d.rearm = 1'b1;
        end
        if (cfg.deep_brownout_on && evt.power_on) begin
          d.ctrl[`DSC_CTRL_HOLD] = 1'b0;
          d.ret0 = 16'h0000;
          d.ret1 = 16'h0000;
        end
        if (evt.ext_interrupt_zero) begin
          d.wake[`DSC_WAKE_INT] = 1'b1;
        end
        if (evt.fault) begin
          d.wake[`DSC_WAKE_FLT] = 1'b1;
        end
        if (w_cal) begin
          d.wake[`DSC_WAKE_CAL] = 1'b1;
        end
        if (wdt_to) begin
          d.wake[`DSC_WAKE_WDT] = 1'b1;
        end
        if (evt.external_reset_pin) begin
          d.wake[`DSC_WAKE_EXTERNAL_RESET_PIN] = 1'b1;
        end
        if (wake_any) begin
          d.mode    = DSC_EXIT;
          d.wreset  = 1'b1;
          d.ctrl[`DSC_CTRL_ARM] = 1'b0;
          if (evt.external_reset_pin && !evt.power_on) begin
            // Registers, hold and oscillator survive; pins go to reset state.
            d.pin_rst = 1'b1;
          end else begin
            d.port_clr = 1'b1;
            d.osc_clr  = 1'b1;
          end
        end
      end
      // One quiet cycle stands for the power-on sequence; events other than power-on are ignored.
      DSC_EXIT: d.mode = DSC_RUN;
      default:  d.mode = DSC_RUN;
    endcase

    // Pins follow the frozen copy while held, with outputs off after a reset-pin wake; the live port otherwise.
    if (d.ctrl[`DSC_CTRL_HOLD]) begin
      d.pin_out  = d.frz_lat;
      d.pin_oe_n = d.pin_rst ? {NPINS{1'b1}} : d.frz_dir;
    end else begin
      d.pin_out  = pin_latch_bits;
      d.pin_oe_n = pin_direction_bits;
      d.pin_rst  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Only the true power-on reset reaches this logic; nothing else clears it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.mode     <= DSC_RUN;
      q.ctrl     <= `DSC_CTRL_RST;
      q.wake     <= `DSC_WAKE_RST;
      q.pin_oe_n <= '1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Handshake readies are combinational; one write and one read at a time.
  assign awready = !q.aw_got && !q.bvalid;
  assign wready  = !q.w_got && !q.bvalid;
  assign arready = !q.rvalid;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;

  assign pin_out  = q.pin_out;
  assign pin_oe_n = q.pin_oe_n;

  // A held oscillator keeps its entry state until release unless the deep watchdog runs from it.
  assign secondary_oscillator_run = (q.ctrl[`DSC_CTRL_HOLD] ? q.frz_osc : secondary_osc_on)
    || (in_deep && cfg.deep_watchdog_on && !cfg.deep_watchdog_clk_sel);
  assign low_power_rc_run = cfg.calendar_clk_sel
    || (in_deep && cfg.deep_watchdog_on && cfg.deep_watchdog_clk_sel);

  assign calendar_tick     = q.cal_tick;
  assign deep_sleep_active = in_deep;
  assign wake_reset        = q.wreset;
  assign port_regs_clear   = q.port_clr;
  assign osc_on_clear      = q.osc_clr;
  assign por_rearm         = q.rearm;
  assign deep_exit_status  = q.st_exit;
  assign power_on_status   = q.st_por;

endmodule : dsc_top

// [dsc_top_monitor.sv]
// Concurrent checks on the ports of the deep sleep controller.
`timescale 1ns/10ps
module dsc_top_monitor
  import dsc_pkg::*;
#(
  parameter int NPINS = 16
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             bvalid,
  input wire logic             rvalid,
  input wire dsc_cfg_type      cfg,
  input wire dsc_evt_type      evt,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe_n,
  input wire logic             deep_sleep_active,
  input wire logic             wake_reset,
  input wire logic             port_regs_clear,
  input wire logic             osc_on_clear,
  input wire logic             por_rearm,
  input wire logic             deep_exit_status,
  input wire logic             power_on_status
);
  default clocking cb @(posedge aclk); endclocking
  ////////////////////////////////////////////////////////////////////////////////
  // Events are compared as whole words, except power-on in a_por_flag, so that a coincident second cause cannot mask a slip.
  a_entry_status: assert property (disable iff (!aresetn)
    $rose(deep_sleep_active) |-> deep_exit_status) else $error("exit status missing on entry");
  a_pins_frozen: assert property (disable iff (!aresetn)
    deep_sleep_active && $past(deep_sleep_active) && !cfg.deep_brownout_on
    |-> $stable(pin_out) && $stable(pin_oe_n)) else $error("pins moved in deep sleep");
  a_wake_pulse: assert property (disable iff (!aresetn)
    deep_sleep_active && evt == 6'h20 |=> wake_reset && !deep_sleep_active ##1 !wake_reset)
    else $error("interrupt wake pulse wrong");
  a_wake_clears: assert property (disable iff (!aresetn)
    deep_sleep_active && evt == 6'h20 |=> port_regs_clear && osc_on_clear)
    else $error("port and oscillator clear missing on wake");
  a_ext_keep: assert property (disable iff (!aresetn)
    deep_sleep_active && evt == 6'h04 |=> wake_reset && !port_regs_clear && !osc_on_clear)
    else $error("external reset wake cleared settings");
  a_bor_stays: assert property (disable iff (!aresetn)
    deep_sleep_active && cfg.deep_brownout_on && evt == 6'h01
    |=> deep_sleep_active && por_rearm && !wake_reset) else $error("brownout woke device");
  a_por_flag: assert property (disable iff (!aresetn)
    evt.power_on |=> power_on_status) else $error("power-on status not set");
  // Reset itself is the cause here, so this one has no disable condition.
  a_reset_idle: assert property (
    !aresetn |=> &pin_oe_n && !bvalid && !rvalid && !deep_sleep_active)
    else $error("state survived power-on reset");
endmodule : dsc_top_monitor

bind dsc_top dsc_top_monitor #(.NPINS(NPINS)) u_dsc_top_monitor (
  .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .rvalid(rvalid), .cfg(cfg), .evt(evt),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .deep_sleep_active(deep_sleep_active),
  .wake_reset(wake_reset), .port_regs_clear(port_regs_clear), .osc_on_clear(osc_on_clear),
  .por_rearm(por_rearm), .deep_exit_status(deep_exit_status),
  .power_on_status(power_on_status));

// [dsc_top_tb.sv]
// Self-checking testbench of the deep sleep controller.
`timescale 1ns/10ps
module dsc_top_tb;
  import dsc_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sleep_cmd, secondary_osc_on;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  dsc_cfg_type cfg;
  dsc_evt_type evt;
  dsc_tick_type tick;
  logic [15:0] pin_direction_bits, pin_latch_bits, pin_out, pin_oe_n;
  logic        secondary_oscillator_run, low_power_rc_run, calendar_tick, deep_sleep_active;
  logic        wake_reset, port_regs_clear, osc_on_clear, por_rearm;
  logic        deep_exit_status, power_on_status;
  int          n_fail, n_tests;

  dsc_top #(.NPINS(16)) u_dsc_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .cfg, .evt, .tick, .sleep_cmd, .pin_direction_bits,
    .pin_latch_bits, .secondary_osc_on, .pin_out, .pin_oe_n, .secondary_oscillator_run,
    .low_power_rc_run, .calendar_tick, .deep_sleep_active, .wake_reset, .port_regs_clear,
    .osc_on_clear, .por_rearm, .deep_exit_status, .power_on_status);

  // Clock at 25 MHz.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, bus and stimulus helpers.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // Address and data are offered together and each is dropped at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, d, e);
  endtask : rc
  task automatic slp();
    @(posedge aclk);
    sleep_cmd <= 1'b1;
    @(posedge aclk);
    sleep_cmd <= 1'b0;
    #1;
  endtask : slp
  task automatic pz(input dsc_evt_type v);
    @(posedge aclk);
    evt <= v;
    @(posedge aclk);
    evt <= 6'h00;
    #1;
  endtask : pz
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge aclk);
      tick <= 2'b01;
      @(posedge aclk);
      tick <= 2'b00;
    end
    #1;
  endtask : tk
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    rc(8'h00, 32'h0, "ctrl reset");
    rc(8'h04, 32'h0, "wake reset");
    rd(8'h20);
    chk("unmapped resp", r, 2'b10);
    wr(8'h08, 32'h1234);
    wr(8'h0C, 32'hBEEF);
    rc(8'h08, 32'h1234, "ret0");
  endtask : t_regs
  task automatic t_int_wake();
    wr(8'h00, 32'h8000);
    slp();
    chk("deep", deep_sleep_active, 1'b1);
    chk("oe frozen", pin_oe_n, 16'h00FF);
    chk("out frozen", pin_out & 16'hFF00, 16'h0F00);
    @(posedge aclk);
    pin_direction_bits <= 16'hFF00;
    pin_latch_bits     <= 16'hF0F0;
    repeat (3) @(posedge aclk);
    #1 chk("oe held", pin_oe_n, 16'h00FF);
    pz(6'h20);
    chk("wake pulse", wake_reset, 1'b1);
    chk("port clear", port_regs_clear, 1'b1);
    chk("osc clear", osc_on_clear, 1'b1);
    rc(8'h04, 32'h100, "wake int");
    rc(8'h00, 32'h1, "arm cleared hold kept");
    rc(8'h10, 32'h1, "exit status");
    chk("oe after wake", pin_oe_n, 16'h00FF);
    wr(8'h00, 32'h0);
    @(posedge aclk);
    #1 chk("oe released", pin_oe_n, 16'hFF00);
    chk("out released", pin_out & 16'h00FF, 16'h00F0);
    wr(8'h10, 32'h0);
    rc(8'h10, 32'h0, "status cleared");
  endtask : t_int_wake
  // Calendar wake is blocked, so only the watchdog can end this sleep.
  task automatic t_wdt();
    wr(8'h00, 32'h8100);
    rc(8'h04, 32'h0, "wake cleared by arm");
    cfg <= 8'hA0;
    slp();
    chk("low_power_rc_osc started", low_power_rc_run, 1'b1);
    pz(6'h08);
    chk("calendar blocked", deep_sleep_active, 1'b1);
    tk(63);
    chk("before timeout", deep_sleep_active, 1'b1);
    tk(1);
    repeat (2) @(posedge aclk);
    #1 chk("after timeout", deep_sleep_active, 1'b0);
    rc(8'h04, 32'h10, "wake watchdog");
  endtask : t_wdt
  task automatic t_ext_reset();
    cfg <= 8'h00;
    wr(8'h00, 32'h8000);
    slp();
    pz(6'h04);
    chk("ext keeps ports", port_regs_clear, 1'b0);
    @(posedge aclk);
    secondary_osc_on <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 chk("ext pins reset", pin_oe_n, 16'hFFFF);
    chk("ext osc kept", secondary_oscillator_run, 1'b1);
    rc(8'h00, 32'h1, "ext hold kept");
    rc(8'h08, 32'h1234, "ext ret0 kept");
    rc(8'h04, 32'h4, "wake ext");
  endtask : t_ext_reset
  task automatic t_brownout();
    cfg <= 8'h40;
    wr(8'h00, 32'h8000);
    slp();
    // Move the live direction so that a release is told apart from the frozen copy.
    @(posedge aclk);
    pin_direction_bits <= 16'h0F0F;
    pz(6'h01);
    chk("no wake", deep_sleep_active, 1'b1);
    chk("rearm pulse", por_rearm, 1'b1);
    rd(8'h00);
    chk("bor flag hold off", d & 32'h3, 32'h2);
    rc(8'h08, 32'h0, "ret0 lost");
    rc(8'h0C, 32'h0, "ret1 lost");
    chk("pins released", pin_oe_n, 16'h0F0F);
    pz(6'h02);
    rc(8'h10, 32'h3, "exit and por");
    rc(8'h04, 32'h1, "wake por");
  endtask : t_brownout
  task automatic t_por_run();
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h0);
    pz(6'h02);
    chk("por status", power_on_status, 1'b1);
    rc(8'h04, 32'h1, "por flag in run");
    rc(8'h10, 32'h2, "normal power-on");
    // Calendar tick must follow the low power RC tick only once that source is picked.
    cfg <= 8'h10;
    tk(1);
    chk("cal from low_power_rc_osc", calendar_tick, 1'b1);
    @(posedge aclk);
    tick <= 2'b10;
    @(posedge aclk);
    tick <= 2'b00;
    #1 chk("cal ignores secondary_oscillator", calendar_tick, 1'b0);
  endtask : t_por_run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // Watchdog on the whole run, well beyond the few hundred cycles the scenarios take.
  initial begin
    #2000000;
    n_fail++;
    summarize();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_cmd} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    secondary_osc_on = 1'b1;
    cfg = 8'h00;
    evt = 6'h00;
    tick = 2'b00;
    pin_direction_bits = 16'h00FF;
    pin_latch_bits = 16'h0F0F;
    n_fail = 0;
    n_tests = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_int_wake();
    t_wdt();
    t_ext_reset();
    t_brownout();
    t_por_run();
    summarize();
  end
endmodule : dsc_top_tb
